// *** hw/logger_control.sv ***
// Design decisions made here: the address map and register access over APB.
`default_nettype none
`include "logger_params.svh"
module logger_control
   import logger_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = 32'((`DEBOUNCE_MS * `CLK_HZ) / `MS_PER_S),
   parameter int unsigned TICK_CYCLES     = 32'(`CLK_HZ / `MS_PER_S)
) (
   input  wire logic                   CLK,
   input  wire logic                   ARST_N,
   input  wire logic                   CE,
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [7:0]             PADDR,
   input  wire logic [31:0]            PWDATA,
   input  wire logic [3:0]             PSTRB,
   output var  logic [31:0]            PRDATA,
   output var  logic                   PREADY,
   output var  logic                   PSLVERR,
   output var  logic                   IRQ,
   input  wire logic                   TRIG_IN,
   input  wire logic                   TOOL_LINK,
   input  wire logic                   TRAFFIC_FIRST,
   input  wire logic                   TRAFFIC_SECOND,
   output var  logic                   TRIG_OUT_LEVEL,
   output var  logic                   TRIG_OUT_OE_N,
   output var  logic                   POWER_STATUS_LAMP,
   output var  logic                   FIRST_CHANNEL_PORT_LAMP,
   output var  logic                   SECOND_CHANNEL_PORT_LAMP,
   output var  logic                   ERROR_LAMP,
   output var  logic                   INFO_LAMP,
   output var  logic                   LOG_MODE,
   output var  logic                   RECORDING,
   output var  logic [1:0]             ERRFRAME_REQ,
   output var  logic [`BITRATE_W-1:0]  BITRATE_KBPS
);
   logic [`CTRL_W-1:0]     ctrl;
   logic [`TRIG_LEN_W-1:0] trig_len;
   logic [`IRQ_W-1:0]      irq_stat;
   logic [`IRQ_W-1:0]      irq_mask;
   log_state_e             state;
   log_state_e             next_state;
   logic [`TRIG_LEN_W-1:0] pulse_cnt;
   logic                   pulse_on;
   logic [31:0]            tick_cnt;
   logic                   tick;
   logic [`MS_W-1:0]       fast_ph;
   logic [`MS_W-1:0]       armed_ph;
   logic [`MS_W-1:0]       run_ph;
   logic [2:0]             run_idx;
   logic [1:0]             flash;
   lamp_vec_t              lamps;
   lamp_vec_t              next_lamps;
   logic                   trig_level;
   logic                   trig_rise;
   logic                   trig_fall;

   // APB decode; read data and error are captured in the setup cycle so the
   // access phase always completes with zero wait states
   wire        setup      = PSEL && !PENABLE;
   wire        wr_access  = PSEL && PENABLE && PWRITE;
   wire        hit_ctrl   = (PADDR == `OFS_CTRL);
   wire        hit_len    = (PADDR == `OFS_TRIG_LEN);
   wire        hit_rate   = (PADDR == `OFS_BITRATE);
   wire        hit_stat   = (PADDR == `OFS_STATUS);
   wire        hit_istat  = (PADDR == `OFS_IRQ_STAT);
   wire        hit_imask  = (PADDR == `OFS_IRQ_MASK);
   wire        hit_cmd    = (PADDR == `OFS_CMD);
   wire        hit_any    = hit_ctrl || hit_len || hit_rate || hit_stat || hit_istat || hit_imask || hit_cmd;
   wire [31:0] lane_mask  = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
   wire [31:0] wdata      = PWDATA & lane_mask;
   wire        wr_ctrl    = wr_access && hit_ctrl;
   wire        wr_len     = wr_access && hit_len;
   wire        wr_rate    = wr_access && hit_rate;
   wire        wr_istat   = wr_access && hit_istat;
   wire        wr_imask   = wr_access && hit_imask;
   wire        wr_cmd     = wr_access && hit_cmd;

   wire [31:0] ctrl_merge = ({27'h000_0000, ctrl} & ~lane_mask) | wdata;
   wire [31:0] len_merge  = ({16'h0000, trig_len} & ~lane_mask) | wdata;
   wire [31:0] rate_merge = ({22'h00_0000, BITRATE_KBPS} & ~lane_mask) | wdata;
   wire [31:0] mask_merge = ({29'h0000_0000, irq_mask} & ~lane_mask) | wdata;
   wire [`BITRATE_W-1:0] rate_new = rate_merge[`BITRATE_W-1:0];
   // Out-of-range rates are dropped whole, old rate stays
   wire        rate_ok    = (rate_merge[31:`BITRATE_W] == 22'h00_0000) &&
                            (rate_new >= `BITRATE_MIN) && (rate_new <= `BITRATE_MAX);

   wire        mode_log   = ctrl[`CTRL_MODE];
   wire        cfg_run    = ctrl[`CTRL_CFG_MODE] && TOOL_LINK;
   wire        trig_event = ctrl[`CTRL_EDGE] ? trig_rise : trig_fall;
   wire        sw_fire    = wr_cmd && wdata[`CMD_FIRE];
   wire        hw_fire    = trig_event && ctrl[`CTRL_TRIG_OUT];
   wire        fire       = sw_fire || hw_fire;
   wire        pulse_end  = pulse_on && (pulse_cnt <= `TRIG_LEN_W'(1)) && !fire;
   wire        rec_start  = (next_state == LOG_RECORDING) && (state != LOG_RECORDING);
   wire [`IRQ_W-1:0] irq_set = {pulse_end, rec_start, trig_event};
   wire [`IRQ_W-1:0] irq_clr = wr_istat ? wdata[`IRQ_W-1:0] : '0;
   // Error frames only in interface mode
   wire [1:0]  errf_req   = (wr_cmd && !mode_log) ? {wdata[`CMD_ERRF_SECOND], wdata[`CMD_ERRF_FIRST]} : 2'h0;

   wire [`STAT_W-1:0] status = {TOOL_LINK, pulse_on, trig_level, (state == LOG_RECORDING),
                                (state == LOG_ARMED), mode_log};
   wire [31:0] rd_mux =
      hit_ctrl  ? {27'h000_0000, ctrl} :
      hit_len   ? {16'h0000, trig_len} :
      hit_rate  ? {22'h00_0000, BITRATE_KBPS} :
      hit_stat  ? {26'h000_0000, status} :
      hit_istat ? {29'h0000_0000, irq_stat} :
      hit_imask ? {29'h0000_0000, irq_mask} :
      32'h0000_0000;

   assign PREADY        = PSEL && PENABLE;
   assign IRQ           = |(irq_stat & irq_mask);
   assign TRIG_OUT_LEVEL = 1'h0;     // Only ever sinks
   assign TRIG_OUT_OE_N = !pulse_on;
   assign LOG_MODE      = mode_log;
   assign RECORDING     = (state == LOG_RECORDING);
   assign {INFO_LAMP, ERROR_LAMP, SECOND_CHANNEL_PORT_LAMP, FIRST_CHANNEL_PORT_LAMP, POWER_STATUS_LAMP} = lamps;

   trigger_debounce #(
      .STABLE_CYCLES (DEBOUNCE_CYCLES)
   ) u_debounce (
      .clk    (CLK),
      .arst_n (ARST_N),
      .ce     (CE),
      .pin    (TRIG_IN),
      .level  (trig_level),
      .rise   (trig_rise),
      .fall   (trig_fall)
   );

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'h0;
      end else if (CE && setup) begin
         PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
         PSLVERR <= !hit_any;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl         <= `CTRL_RST;
         trig_len     <= `TRIG_LEN_RST;
         BITRATE_KBPS <= `BITRATE_RST;
         irq_mask     <= `IRQ_MASK_RST;
      end else if (CE) begin
         if (wr_ctrl) ctrl <= ctrl_merge[`CTRL_W-1:0];
         if (wr_len) trig_len <= len_merge[`TRIG_LEN_W-1:0];
         if (wr_rate && rate_ok) BITRATE_KBPS <= rate_new;
         if (wr_imask) irq_mask <= mask_merge[`IRQ_W-1:0];
      end
   end

   // Hardware set wins over a write-one clear in the same cycle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_stat <= '0;
      end else if (CE) begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ERRFRAME_REQ <= 2'h0;
      end else if (CE) begin
         ERRFRAME_REQ <= errf_req;
      end else begin
         ERRFRAME_REQ <= 2'h0;
      end
   end

   // Logging start: straight after entry (CTRL_MODE set) or on trigger
   always_comb begin
      next_state = state;
      unique case (state)
         LOG_IDLE: begin
            if (mode_log) next_state = ctrl[`CTRL_START_TRIG] ? LOG_ARMED : LOG_RECORDING;
         end
         LOG_ARMED: begin
            if (!mode_log) next_state = LOG_IDLE;
            else if (trig_event) next_state = LOG_RECORDING;
         end
         LOG_RECORDING: begin
            if (!mode_log) next_state = LOG_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= LOG_IDLE;
      end else if (CE) begin
         state <= next_state;
      end
   end

   // Retrigger restarts the pulse; a zero length still gives one cycle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pulse_on  <= 1'h0;
         pulse_cnt <= '0;
      end else if (CE) begin
         if (fire) begin
            pulse_on  <= 1'h1;
            pulse_cnt <= trig_len;
         end else if (pulse_end) begin
            pulse_on  <= 1'h0;
            pulse_cnt <= '0;
         end else if (pulse_on) begin
            pulse_cnt <= pulse_cnt - `TRIG_LEN_W'(1);
         end
      end
   end

   // Millisecond prescaler; runs regardless of mode so patterns stay smooth
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_cnt <= '0;
         tick     <= 1'h0;
      end else if (CE) begin
         tick     <= (tick_cnt == TICK_CYCLES - 32'd1);
         tick_cnt <= (tick_cnt == TICK_CYCLES - 32'd1) ? 32'd0 : tick_cnt + 32'd1;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         fast_ph  <= '0;
         armed_ph <= '0;
         run_ph   <= '0;
         run_idx  <= '0;
      end else if (CE && tick) begin
         fast_ph  <= (fast_ph == `FAST_PERIOD_MS - `MS_W'(1)) ? '0 : fast_ph + `MS_W'(1);
         armed_ph <= (armed_ph == `ARMED_PERIOD_MS - `MS_W'(1)) ? '0 : armed_ph + `MS_W'(1);
         if (run_ph == `RUN_STEP_MS - `MS_W'(1)) begin
            run_ph  <= '0;
            run_idx <= (run_idx == 3'(`LAMP_COUNT - 1)) ? 3'h0 : run_idx + 3'h1;
         end else begin
            run_ph <= run_ph + `MS_W'(1);
         end
      end
   end

   // Per-channel flash stretcher; a busy bus keeps it lit steadily
   wire [1:0] traffic = {TRAFFIC_SECOND, TRAFFIC_FIRST};
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_flash
         logic [`MS_W-1:0] left;
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               left <= '0;
            end else if (CE) begin
               if (traffic[ch]) left <= `FLASH_MS;
               else if (tick && (left != '0)) left <= left - `MS_W'(1);
            end
         end
         assign flash[ch] = (left != '0);
      end
   endgenerate

   wire power_fast  = (fast_ph < `FAST_ON_MS);
   wire power_armed = (armed_ph < `ARMED_ON_MS);

   always_comb begin
      next_lamps = '0;
      if (cfg_run) begin
         next_lamps = lamp_vec_t'(5'h01 << run_idx);
      end else if (!mode_log) begin
         next_lamps[0]   = 1'h1;
         next_lamps[2:1] = flash;
      end else begin
         unique case (state)
            LOG_ARMED:     next_lamps[0] = power_armed;
            LOG_RECORDING: next_lamps[0] = power_fast;
            LOG_IDLE:      next_lamps[0] = 1'h0;
         endcase
         next_lamps[2:1] = flash;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         lamps <= '0;
      end else if (CE) begin
         lamps <= next_lamps;
      end
   end
endmodule : logger_control
`default_nettype wire

// *** hw/logger_params.svh ***
`ifndef LOGGER_PARAMS_SVH
`define LOGGER_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_TRIG_LEN    8'h04
`define OFS_BITRATE     8'h08
`define OFS_STATUS      8'h0C
`define OFS_IRQ_STAT    8'h10
`define OFS_IRQ_MASK    8'h14
`define OFS_CMD         8'h18

// Control register fields
`define CTRL_MODE       0
`define CTRL_EDGE       1
`define CTRL_START_TRIG 2
`define CTRL_TRIG_OUT   3
`define CTRL_CFG_MODE   4
`define CTRL_W          5
`define CTRL_RST        5'h00

// Command register fields (write-only strobes)
`define CMD_FIRE        0
`define CMD_ERRF_FIRST  1
`define CMD_ERRF_SECOND 2

// Interrupt status / mask fields
`define IRQ_TRIG        0
`define IRQ_REC         1
`define IRQ_PULSE_DONE  2
`define IRQ_W           3
`define IRQ_MASK_RST    3'h0

// Status register fields
`define STAT_MODE       0
`define STAT_ARMED      1
`define STAT_REC        2
`define STAT_TRIG_LVL   3
`define STAT_PULSE      4
`define STAT_TOOL       5
`define STAT_W          6

// Trigger output pulse length in clock cycles
`define TRIG_LEN_W      16
`define TRIG_LEN_RST    16'h03E8

// Bit rate in kbit/s
`define BITRATE_W       10
`define BITRATE_RST     10'h1F4
`define BITRATE_MIN     10'h00A
`define BITRATE_MAX     10'h3E8

// Timing
`define CLK_HZ          64'd100000000
`define DEBOUNCE_MS     64'd30
`define MS_PER_S        64'd1000
`define MS_W            10
`define FAST_PERIOD_MS  10'h064
`define FAST_ON_MS      10'h032
`define ARMED_PERIOD_MS 10'h3E8
`define ARMED_ON_MS     10'h384
`define FLASH_MS        10'h032
`define RUN_STEP_MS     10'h064
`define LAMP_COUNT      5

`endif

// *** hw/logger_pkg.sv ***
`default_nettype none
package logger_pkg;
   typedef enum logic {
      MODE_INTERFACE,
      MODE_LOGGING
   } log_mode_e;

   typedef enum logic [1:0] {
      LOG_IDLE,
      LOG_ARMED,
      LOG_RECORDING
   } log_state_e;

   typedef logic [4:0] lamp_vec_t;
endpackage : logger_pkg
`default_nettype wire

// *** hw/trigger_debounce.sv ***
`default_nettype none
`include "logger_params.svh"
module trigger_debounce
   import logger_pkg::*;
#(
   parameter int unsigned STABLE_CYCLES = 32'd3000000
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic pin,
   output var  logic level,
   output var  logic rise,
   output var  logic fall
);
   logic        sync1;
   logic        sync2;
   logic        sync3;
   logic [31:0] stable_cnt;

   wire agree   = (sync2 == sync3);
   wire differs = agree && (sync3 != level);
   wire settled = differs && (stable_cnt == STABLE_CYCLES - 32'd1);

   // Flops reset high: a floating pin is pulled up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 1'h1;
         sync2 <= 1'h1;
         sync3 <= 1'h1;
      end else if (ce) begin
         sync1 <= pin;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Any disagreement or bounce restarts the stability count
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stable_cnt <= '0;
         level      <= 1'h1;
         rise       <= 1'h0;
         fall       <= 1'h0;
      end else if (ce) begin
         rise <= settled && sync3;
         fall <= settled && !sync3;
         if (settled) begin
            level      <= sync3;
            stable_cnt <= '0;
         end else if (differs) begin
            stable_cnt <= stable_cnt + 32'd1;
         end else begin
            stable_cnt <= '0;
         end
      end else begin
         rise <= 1'h0;
         fall <= 1'h0;
      end
   end
endmodule : trigger_debounce
`default_nettype wire

// *** tb/logger_checker_assertions.sv ***
`default_nettype none
`include "logger_params.svh"
module logger_checker (
   input wire logic                  CLK,
   input wire logic                  ARST_N,
   input wire logic                  PSEL,
   input wire logic                  PENABLE,
   input wire logic                  PWRITE,
   input wire logic [7:0]            PADDR,
   input wire logic [31:0]           PWDATA,
   input wire logic                  PREADY,
   input wire logic                  TOOL_LINK,
   input wire logic                  TRAFFIC_FIRST,
   input wire logic                  TRAFFIC_SECOND,
   input wire logic                  TRIG_OUT_LEVEL,
   input wire logic                  POWER_STATUS_LAMP,
   input wire logic                  FIRST_CHANNEL_PORT_LAMP,
   input wire logic                  SECOND_CHANNEL_PORT_LAMP,
   input wire logic                  LOG_MODE,
   input wire logic                  RECORDING,
   input wire logic [1:0]            ERRFRAME_REQ,
   input wire logic [`BITRATE_W-1:0] BITRATE_KBPS
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       acc_wr;
   logic       cmd_ok;
   logic [1:0] settled;
   assign acc_wr = PSEL && PENABLE && PWRITE;
   assign cmd_ok = acc_wr && PADDR == `OFS_CMD && !LOG_MODE;
   // Power lamp shows one edge after reset; the check waits for three
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         settled <= 2'h0;
      end else if (settled != 2'h3) begin
         settled <= settled + 2'h1;
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   sequence s_hit_first;
      TRAFFIC_FIRST && !TOOL_LINK;
   endsequence
   sequence s_hit_second;
      TRAFFIC_SECOND && !TOOL_LINK;
   endsequence
   property p_ready;
      PREADY == (PSEL && PENABLE);
   endproperty
   property p_pull_down;
      TRIG_OUT_LEVEL == 1'b0;
   endproperty
   property p_errf;
      ERRFRAME_REQ != 2'h0 |-> $past(cmd_ok) || $past(cmd_ok, 2);
   endproperty
   property p_rec_mode;
      RECORDING |-> LOG_MODE || $past(LOG_MODE);
   endproperty
   property p_mode_src;
      $changed(LOG_MODE) |-> $past(acc_wr && PADDR == `OFS_CTRL);
   endproperty
   property p_rate;
      BITRATE_KBPS >= `BITRATE_MIN && BITRATE_KBPS <= `BITRATE_MAX;
   endproperty
   property p_lit_first;
      s_hit_first |-> ##[1:2] FIRST_CHANNEL_PORT_LAMP [*8];
   endproperty
   property p_lit_second;
      s_hit_second |-> ##[1:2] SECOND_CHANNEL_PORT_LAMP [*8];
   endproperty
   property p_power_on;
      settled == 2'h3 && !LOG_MODE && !$past(LOG_MODE) && !TOOL_LINK && !$past(TOOL_LINK) |-> POWER_STATUS_LAMP;
   endproperty
   a_ready: assert property (p_ready) else $error("pready off");
   a_pull_down: assert property (p_pull_down) else $error("trigger out driven high");
   a_errf: assert property (p_errf) else $error("stray error frame");
   a_rec_mode: assert property (p_rec_mode) else $error("recording outside logging");
   a_mode_src: assert property (p_mode_src) else $error("mode changed alone");
   a_rate: assert property (p_rate) else $error("bit rate out of range");
   a_lit_first: assert property (p_lit_first) else $error("first lamp dark");
   a_lit_second: assert property (p_lit_second) else $error("second lamp dark");
   a_power_on: assert property (p_power_on) else $error("power lamp dark");
endmodule : logger_checker
bind logger_control logger_checker logger_checker_inst (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
   .PREADY, .TOOL_LINK, .TRAFFIC_FIRST, .TRAFFIC_SECOND, .TRIG_OUT_LEVEL, .POWER_STATUS_LAMP,
   .FIRST_CHANNEL_PORT_LAMP, .SECOND_CHANNEL_PORT_LAMP, .LOG_MODE, .RECORDING, .ERRFRAME_REQ, .BITRATE_KBPS);
`default_nettype wire

// *** tb/logger_control_tb.sv ***
`default_nettype none
`include "logger_params.svh"
module logger_control_tb
   import logger_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK = 1'b0, ARST_N = 1'b0, CE = 1'b1, press = 1'b0;
   logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic [3:0]  PSTRB = 4'hF;
   logic        TOOL_LINK = 1'b0, TRAFFIC_FIRST = 1'b0, TRAFFIC_SECOND = 1'b0;
   logic        PREADY, PSLVERR, IRQ, TRIG_IN, TRIG_OUT_LEVEL, TRIG_OUT_OE_N, LOG_MODE, RECORDING;
   logic        POWER_STATUS_LAMP, FIRST_CHANNEL_PORT_LAMP, SECOND_CHANNEL_PORT_LAMP, ERROR_LAMP, INFO_LAMP;
   logic [1:0]  ERRFRAME_REQ;
   logic [9:0]  BITRATE_KBPS;
   lamp_vec_t   lamps;
   int          n_errors = 0, checks_done = 0, cyc = 0;
   assign lamps = {INFO_LAMP, ERROR_LAMP, SECOND_CHANNEL_PORT_LAMP, FIRST_CHANNEL_PORT_LAMP, POWER_STATUS_LAMP};
   logger_control #(.DEBOUNCE_CYCLES(8), .TICK_CYCLES(4)) logger_control_inst (.CLK, .ARST_N, .CE, .PSEL,
      .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR, .IRQ, .TRIG_IN, .TOOL_LINK,
      .TRAFFIC_FIRST, .TRAFFIC_SECOND, .TRIG_OUT_LEVEL, .TRIG_OUT_OE_N, .POWER_STATUS_LAMP, .FIRST_CHANNEL_PORT_LAMP,
      .SECOND_CHANNEL_PORT_LAMP, .ERROR_LAMP, .INFO_LAMP, .LOG_MODE, .RECORDING, .ERRFRAME_REQ, .BITRATE_KBPS);
   trigger_source trigger_source_inst (.clk(CLK), .press(press), .pin(TRIG_IN));
   always #5 CLK = ~CLK;
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= wr;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      @(posedge CLK);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
      chk(e, eexp);
   endtask : rd
   task automatic hold(input logic v);
      press <= v;
      repeat (40) @(posedge CLK);
   endtask : hold
   task automatic errf(input logic [1:0] exp);
      logic [1:0]  seen;
      logic [31:0] q;
      logic        e;
      // Request stands only in the cycle after the access edge
      apb(1'b1, `OFS_CMD, 32'h6, q, e);
      seen = 2'h0;
      repeat (3) @(posedge CLK) seen |= ERRFRAME_REQ;
      chk(seen, exp);
   endtask : errf
   task automatic traffic();
      TRAFFIC_FIRST  <= 1'b1;
      TRAFFIC_SECOND <= 1'b1;
      @(posedge CLK);
      TRAFFIC_FIRST  <= 1'b0;
      TRAFFIC_SECOND <= 1'b0;
      repeat (3) @(posedge CLK);
      chk({FIRST_CHANNEL_PORT_LAMP, SECOND_CHANNEL_PORT_LAMP}, 32'h3);
      repeat (300) @(posedge CLK);
      chk({FIRST_CHANNEL_PORT_LAMP, SECOND_CHANNEL_PORT_LAMP}, 32'h0);
   endtask : traffic
   task automatic t_reset();
      rd(`OFS_CTRL, 32'h0, 1'b0);
      rd(`OFS_TRIG_LEN, 32'h03E8, 1'b0);
      rd(`OFS_BITRATE, 32'h01F4, 1'b0);
      rd(`OFS_STATUS, 32'h8, 1'b0);
      rd(`OFS_IRQ_MASK, 32'h0, 1'b0);
      rd(`OFS_CMD, 32'h0, 1'b0);
      rd(8'h1C, 32'h0, 1'b1);
      chk({POWER_STATUS_LAMP, TRIG_OUT_OE_N}, 32'h3);
   endtask : t_reset
   task automatic t_bitrate();
      logic [9:0] req [4] = '{10'h00A, 10'h3E8, 10'h009, 10'h3E9};
      logic [9:0] exp [4] = '{10'h00A, 10'h3E8, 10'h3E8, 10'h3E8};
      for (int i = 0; i < 4; i++) begin
         wr(`OFS_BITRATE, {22'h0, req[i]});
         chk(BITRATE_KBPS, exp[i]);
      end
   endtask : t_bitrate
   task automatic t_fall();
      int n;
      wr(`OFS_IRQ_MASK, 32'h1);
      wr(`OFS_TRIG_LEN, 32'h3);
      wr(`OFS_CTRL, 32'h8);
      press <= 1'b1;
      repeat (5) @(posedge CLK);
      hold(1'b0);
      chk(IRQ, 32'h0);
      press <= 1'b1;
      n = 0;
      while (TRIG_OUT_OE_N === 1'b1 && n < 60) begin
         @(posedge CLK);
         n++;
      end
      n = 0;
      while (TRIG_OUT_OE_N === 1'b0 && n < 60) begin
         @(posedge CLK);
         n++;
      end
      chk(n, 32'h3);
      chk(IRQ, 32'h1);
      rd(`OFS_STATUS, 32'h0, 1'b0);
      wr(`OFS_IRQ_STAT, 32'h1);
      chk(IRQ, 32'h0);
      hold(1'b0);
      chk(IRQ, 32'h0);
   endtask : t_fall
   task automatic t_rise();
      wr(`OFS_IRQ_MASK, 32'h0);
      wr(`OFS_CTRL, 32'hA);
      hold(1'b1);
      rd(`OFS_IRQ_STAT, 32'h4, 1'b0);
      hold(1'b0);
      chk(IRQ, 32'h0);
      rd(`OFS_IRQ_STAT, 32'h5, 1'b0);
      wr(`OFS_IRQ_MASK, 32'h1);
      chk(IRQ, 32'h1);
      wr(`OFS_IRQ_STAT, 32'h7);
      chk(IRQ, 32'h0);
      wr(`OFS_CMD, 32'h1);
      chk({TRIG_OUT_OE_N, IRQ}, 32'h0);
      rd(`OFS_STATUS, 32'h18, 1'b0);
      rd(`OFS_IRQ_STAT, 32'h4, 1'b0);
      wr(`OFS_IRQ_STAT, 32'h4);
   endtask : t_rise
   task automatic t_log();
      int on;
      wr(`OFS_CTRL, 32'h1);
      @(posedge CLK);
      chk({LOG_MODE, RECORDING}, 32'h3);
      rd(`OFS_IRQ_STAT, 32'h2, 1'b0);
      on = 0;
      repeat (400) @(posedge CLK) on += POWER_STATUS_LAMP;
      chk(on, 32'hC8);
      errf(2'h0);
      traffic();
      // Start choice is taken on entry to logging only
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_CTRL, 32'h5);
      rd(`OFS_STATUS, 32'hB, 1'b0);
      on = 0;
      repeat (4000) @(posedge CLK) on += POWER_STATUS_LAMP;
      chk(on, 32'h0E10);
      hold(1'b1);
      chk(RECORDING, 32'h1);
      hold(1'b0);
      wr(`OFS_CTRL, 32'h0);
      errf(2'h3);
      traffic();
   endtask : t_log
   task automatic t_cfg();
      lamp_vec_t seen;
      int        bad;
      TOOL_LINK <= 1'b1;
      wr(`OFS_CTRL, 32'h10);
      rd(`OFS_STATUS, 32'h28, 1'b0);
      @(posedge CLK);
      bad  = 0;
      seen = 5'h00;
      repeat (2000) begin
         @(posedge CLK);
         bad += !$onehot(lamps);
         seen |= lamps;
      end
      chk({bad[26:0], seen}, 32'h1F);
      TOOL_LINK <= 1'b0;
      wr(`OFS_CTRL, 32'h0);
   endtask : t_cfg
   initial begin
      repeat (20) @(posedge CLK);
      ARST_N <= 1'b1;
      t_reset();
      t_bitrate();
      t_fall();
      t_rise();
      t_log();
      t_cfg();
      close_out();
   end
endmodule : logger_control_tb
`default_nettype wire

// *** tb/trigger_source.sv ***
`default_nettype none
module trigger_source (
   input wire logic clk,
   input wire logic press,
   output var logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       last   = 1'b0;
   logic [1:0] bounce = 2'h0;
   // Contacts chatter for a few cycles after every move
   always @(posedge clk) begin
      if (press != last) begin
         last   <= press;
         bounce <= 2'h3;
      end else if (bounce != 2'h0) begin
         bounce <= bounce - 2'h1;
      end
   end
   // Released switch leaves the line at the pull-up
   assign pin = (bounce != 2'h0) ? bounce[0] : !last;
endmodule : trigger_source
`default_nettype wire
